// >>> ebwc_params.svh
`ifndef EBWC_PARAMS_SVH
`define EBWC_PARAMS_SVH
// Register byte addresses, individual range
`define EBWC_ADDR_LOOP_IO 12'h000
`define EBWC_ADDR_LOOP_REG 12'h004
`define EBWC_ADDR_USER 12'h008
`define EBWC_ADDR_MAST 12'h00C
`define EBWC_ADDR_IOOFF 12'h010
`define EBWC_ADDR_IOON 12'h014
`define EBWC_ADDR_RSTON 12'h018
`define EBWC_ADDR_CHECK_I 12'h020
`define EBWC_ADDR_CHECK_II 12'h024
`define EBWC_ADDR_STATUS 12'h028
`define EBWC_ADDR_LATCH 12'h02C
// Broadcast range base, same offsets as registers 0 to 2
`define EBWC_BCAST_BIT 11
// User control codes
`define EBWC_UC_NOP 8'h00
`define EBWC_UC_OFF 8'h01
`define EBWC_UC_ON 8'h02
`define EBWC_UC_PULSE 8'h03
`define EBWC_UC_INV 8'h04
`define EBWC_UC_SWINH 8'h80
`define EBWC_UC_SWEN 8'h81
`define EBWC_UC_CLRINH 8'h84
`define EBWC_UC_LIM32 8'h85
`define EBWC_UC_LIM160 8'h86
`define EBWC_UC_MASK 8'h78
// Mastership codes
`define EBWC_MS_II_SYNC 8'h32
`define EBWC_MS_II 8'h22
`define EBWC_MS_I_SYNC 8'h44
`define EBWC_MS_I 8'h54
`define EBWC_MS_DEFAULT 8'h07
`define EBWC_MS_NONE_SU 8'h86
`define EBWC_MS_NONE 8'h06
// Register number field check
`define EBWC_NUM_IOOFF 3'h4
`define EBWC_NUM_IOON 3'h5
`define EBWC_NUM_RSTON 3'h6
// Frequency limits
`define EBWC_LIM_LOW 8'h20
`define EBWC_LIM_HIGH 8'hA0
// Times
`define EBWC_CLK_NS 100
`define EBWC_PULSE_MIN_US 75
`define EBWC_NOMAST_MIN_MS 39
`define EBWC_WDOG_MIN_MS 3500
`define EBWC_HOLD_MS 200
`define EBWC_INTERVAL_MS 3200
`endif

// >>> ebwc_pkg.sv
package ebwc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ebwc_apb_req_type;
  typedef struct packed {
    logic soft_inhibit;
    logic limit_is_32;
    logic clear_all;
    logic restart_interval;
  } ebwc_int_ctrl_type;
  typedef enum logic [2:0] {
    EBWC_M_I = 3'b001,
    EBWC_M_II = 3'b010,
    EBWC_M_NONE = 3'b100
  } ebwc_master_type;
endpackage

// >>> ebwc_top.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ebwc_params.svh"
// How it works
// - Check write ready only on jumper match
// - Checks allowed async, no status capture
// - Mismatch withholds ready, bus times out
// - Registers 0-2 also accept broadcast-range writes
// - Broadcast to 0 flags addressing error
// - Broadcast to 1 or 2 no fault
// - Register 0 stores, reads back byte
// - Register 1 stores, reads back byte
// - User bits 6-3 only reach latch
// - Codes 1-4 drive aux output, off reset
// - Pulse code gives 75-130 us high
// - 128 inhibits, limit 160; 129 enables
// - 132 clears inhibitions, restarts interval
// - Limit codes set 32/160, clear counter unless freq fault
// - Mastership codes 32H/22H II, 44H/54H I
// - Mastership reset value 07H, default master
// - 06H/86H no master, temporary inhibition
// - No master: I/O reset after 39-54 ms
// - Watchdog 3.5-4 s resets, holds 200 ms
// - Each CPU writes mastership independently
// - Registers 4-6 need number in bits 2:0
// - Software reset line not stretched
module ebwc_top #(
  parameter int PULSE_CYC = (`EBWC_PULSE_MIN_US * 1000 + `EBWC_CLK_NS - 1)
    / `EBWC_CLK_NS,
  parameter int NOMAST_CYC = `EBWC_NOMAST_MIN_MS * 10000,
  parameter int WDOG_CYC = `EBWC_WDOG_MIN_MS * 10000,
  parameter int HOLD_CYC = `EBWC_HOLD_MS * 10000,
  parameter int INTERVAL_CYC = `EBWC_INTERVAL_MS * 10000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Context from the redundant bus side
  input wire logic cpu_ii_side,
  input wire logic sync_mode,
  input wire logic [7:0] jumper_i_pin,
  input wire logic [7:0] jumper_ii_pin,
  input wire logic freq_fault,
  // Outputs
  output logic aux_24v_output,
  output logic extension_io_reset_line,
  output logic io_control_on,
  output logic access_acknowledge_err,
  output logic status_capture,
  output logic temp_inhibit,
  output logic unit_reset,
  output logic startup_flag,
  output ebwc_pkg::ebwc_int_ctrl_type int_ctrl,
  output logic [7:0] int_limit,
  output logic [31:0] interval_count
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] jmp_i_s1_reg, jmp_i_reg, jmp_ii_s1_reg, jmp_ii_reg;
  logic sync_s1_reg, sync_reg, ff_s1_reg, ff_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      jmp_i_s1_reg <= 8'h00;
      jmp_i_reg <= 8'h00;
      jmp_ii_s1_reg <= 8'h00;
      jmp_ii_reg <= 8'h00;
      sync_s1_reg <= 1'b0;
      sync_reg <= 1'b0;
      ff_s1_reg <= 1'b0;
      ff_reg <= 1'b0;
    end else if (clk_en) begin
      jmp_i_s1_reg <= jumper_i_pin;
      jmp_i_reg <= jmp_i_s1_reg;
      jmp_ii_s1_reg <= jumper_ii_pin;
      jmp_ii_reg <= jmp_ii_s1_reg;
      sync_s1_reg <= sync_mode;
      sync_reg <= sync_s1_reg;
      ff_s1_reg <= freq_fault;
      ff_reg <= ff_s1_reg;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  logic bcast, setup, acc;
  logic [11:0] ofs;
  logic [7:0] wbyte;
  logic is_chk_i, is_chk_ii, is_chk, is_mapped, chk_ok;
  logic internal_rst, nomaster, wr_fire;

  assign bcast = paddr[`EBWC_BCAST_BIT];
  assign ofs = {1'b0, paddr[10:0]};
  assign wbyte = pwdata[7:0];
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign is_chk_i = !bcast && hit(ofs, `EBWC_ADDR_CHECK_I);
  assign is_chk_ii = !bcast && hit(ofs, `EBWC_ADDR_CHECK_II);
  assign is_chk = is_chk_i || is_chk_ii;
  // Broadcast only reaches registers 0 to 2
  assign is_mapped = bcast ? (hit(ofs, `EBWC_ADDR_LOOP_IO) ||
    hit(ofs, `EBWC_ADDR_LOOP_REG) || hit(ofs, `EBWC_ADDR_USER)) && pwrite
    : (ofs <= `EBWC_ADDR_LATCH) && (ofs[1:0] == 2'b00) &&
    (ofs != 12'h01C);
  assign chk_ok = is_chk_i ? (wbyte == jmp_i_reg) : (wbyte == jmp_ii_reg);
  assign internal_rst = srst || unit_reset;

  // Ready: check writes wait for comparator match, else time out
  always_comb begin
    if (is_chk && pwrite) begin
      pready = acc && chk_ok;
    end else if (nomaster && !is_chk) begin
      pready = 1'b0;
    end else begin
      pready = acc;
    end
  end
  assign pslverr = acc && pready && !is_mapped;
  assign wr_fire = acc && pready && pwrite && is_mapped && clk_en;

  // ****************************************
  // Data registers 0 and 1, readback latch
  // ****************************************
  logic [7:0] loop_io_reg, loop_reg_reg, latch_reg;

  always_ff @(posedge clock) begin
    if (internal_rst) begin
      loop_io_reg <= 8'h00;
      loop_reg_reg <= 8'h00;
      latch_reg <= 8'h00;
    end else if (wr_fire && !is_chk) begin
      latch_reg <= wbyte;
      if (hit(ofs, `EBWC_ADDR_LOOP_IO)) begin
        loop_io_reg <= wbyte;
      end
      if (hit(ofs, `EBWC_ADDR_LOOP_REG)) begin
        loop_reg_reg <= wbyte;
      end
    end
  end

  // Broadcast to register 0 signals addressing error; 1/2 do not
  always_ff @(posedge clock) begin
    if (internal_rst) begin
      access_acknowledge_err <= 1'b0;
    end else if (clk_en) begin
      access_acknowledge_err <= wr_fire && bcast &&
        hit(ofs, `EBWC_ADDR_LOOP_IO);
    end
  end

  // Status capture pulse, never for check registers
  always_ff @(posedge clock) begin
    if (internal_rst) begin
      status_capture <= 1'b0;
    end else if (clk_en) begin
      status_capture <= acc && pready && is_mapped && !is_chk;
    end
  end

  // ****************************************
  // User control: aux output and interrupts
  // ****************************************
  logic [15:0] pulse_cnt_reg;
  logic user_wr;
  logic [7:0] ucode;

  assign user_wr = wr_fire && hit(ofs, `EBWC_ADDR_USER);
  assign ucode = wbyte & ~`EBWC_UC_MASK;

  always_ff @(posedge clock) begin
    if (internal_rst) begin
      aux_24v_output <= 1'b0;
      pulse_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (pulse_cnt_reg != 16'h0000) begin
        pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
        if (pulse_cnt_reg == 16'h0001) begin
          aux_24v_output <= 1'b0;
        end
      end
      if (user_wr) begin
        case (ucode)
          `EBWC_UC_OFF: begin
            aux_24v_output <= 1'b0;
            pulse_cnt_reg <= 16'h0000;
          end
          `EBWC_UC_ON: begin
            aux_24v_output <= 1'b1;
            pulse_cnt_reg <= 16'h0000;
          end
          `EBWC_UC_PULSE: begin
            aux_24v_output <= 1'b1;
            pulse_cnt_reg <= 16'(PULSE_CYC);
          end
          `EBWC_UC_INV: begin
            aux_24v_output <= !aux_24v_output;
            pulse_cnt_reg <= 16'h0000;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (internal_rst) begin
      int_ctrl <= '0;
      int_limit <= `EBWC_LIM_HIGH;
    end else if (clk_en) begin
      int_ctrl.clear_all <= 1'b0;
      int_ctrl.restart_interval <= 1'b0;
      if (user_wr) begin
        case (ucode)
          `EBWC_UC_SWINH: begin
            int_ctrl.soft_inhibit <= 1'b1;
            int_limit <= `EBWC_LIM_HIGH;
            int_ctrl.limit_is_32 <= 1'b0;
          end
          `EBWC_UC_SWEN: int_ctrl.soft_inhibit <= 1'b0;
          `EBWC_UC_CLRINH: begin
            int_ctrl.soft_inhibit <= 1'b0;
            int_ctrl.clear_all <= 1'b1;
            int_ctrl.restart_interval <= 1'b1;
          end
          `EBWC_UC_LIM32: begin
            int_limit <= `EBWC_LIM_LOW;
            int_ctrl.limit_is_32 <= 1'b1;
            int_ctrl.restart_interval <= !ff_reg;
          end
          `EBWC_UC_LIM160: begin
            int_limit <= `EBWC_LIM_HIGH;
            int_ctrl.limit_is_32 <= 1'b0;
            int_ctrl.restart_interval <= !ff_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Frequency monitor interval, restarted by code
  always_ff @(posedge clock) begin
    if (internal_rst) begin
      interval_count <= 32'h0000_0000;
    end else if (clk_en) begin
      if (int_ctrl.restart_interval ||
        interval_count == 32'(INTERVAL_CYC - 1)) begin
        interval_count <= 32'h0000_0000;
      end else begin
        interval_count <= interval_count + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Mastership, per-CPU enables
  // ****************************************
  logic [7:0] mast_reg;
  logic en_i_reg, en_ii_reg, mast_wr;
  ebwc_pkg::ebwc_master_type master;

  assign mast_wr = wr_fire && hit(ofs, `EBWC_ADDR_MAST);

  always_ff @(posedge clock) begin
    if (internal_rst) begin
      mast_reg <= `EBWC_MS_DEFAULT;
      en_i_reg <= 1'b1;
      en_ii_reg <= 1'b0;
    end else if (mast_wr) begin
      mast_reg <= wbyte;
      case (wbyte)
        `EBWC_MS_II_SYNC: begin
          if (sync_reg) begin
            en_i_reg <= 1'b0;
            en_ii_reg <= 1'b1;
          end
        end
        `EBWC_MS_II: begin
          // CPU I drops its enable, CPU II sets its own; II needs both
          if (cpu_ii_side) begin
            en_ii_reg <= 1'b1;
          end else begin
            en_i_reg <= 1'b0;
          end
        end
        `EBWC_MS_I_SYNC: begin
          if (sync_reg) begin
            en_i_reg <= 1'b1;
            en_ii_reg <= 1'b0;
          end
        end
        `EBWC_MS_I: begin
          // Each side acts on its own enable only
          if (cpu_ii_side) begin
            en_ii_reg <= 1'b0;
          end else begin
            en_i_reg <= 1'b1;
          end
        end
        `EBWC_MS_DEFAULT: begin
          en_i_reg <= 1'b1;
          en_ii_reg <= 1'b0;
        end
        `EBWC_MS_NONE, `EBWC_MS_NONE_SU: begin
          en_i_reg <= 1'b0;
          en_ii_reg <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    if (en_i_reg) begin
      master = ebwc_pkg::EBWC_M_I;
    end else if (en_ii_reg) begin
      master = ebwc_pkg::EBWC_M_II;
    end else begin
      master = ebwc_pkg::EBWC_M_NONE;
    end
  end

  // Temporary inhibition and start-up flag
  always_ff @(posedge clock) begin
    if (internal_rst) begin
      temp_inhibit <= 1'b0;
    end else if (wr_fire && !is_chk) begin
      temp_inhibit <= mast_wr && (wbyte == `EBWC_MS_NONE ||
        wbyte == `EBWC_MS_NONE_SU);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      startup_flag <= 1'b1;
    end else if (unit_reset) begin
      startup_flag <= 1'b1;
    end else if (mast_wr && wbyte == `EBWC_MS_NONE_SU) begin
      startup_flag <= 1'b0;
    end
  end

  // ****************************************
  // No-master delay and I/O reset line
  // ****************************************
  logic [31:0] nm_cnt_reg;
  logic sw_rst_reg, ctl_wr4, ctl_wr5, ctl_wr6;

  assign ctl_wr4 = wr_fire && hit(ofs, `EBWC_ADDR_IOOFF) &&
    wbyte[2:0] == `EBWC_NUM_IOOFF;
  assign ctl_wr5 = wr_fire && hit(ofs, `EBWC_ADDR_IOON) &&
    wbyte[2:0] == `EBWC_NUM_IOON;
  assign ctl_wr6 = wr_fire && hit(ofs, `EBWC_ADDR_RSTON) &&
    wbyte[2:0] == `EBWC_NUM_RSTON;

  always_ff @(posedge clock) begin
    if (internal_rst) begin
      nm_cnt_reg <= 32'h0000_0000;
      nomaster <= 1'b0;
    end else if (clk_en) begin
      if (master != ebwc_pkg::EBWC_M_NONE) begin
        nm_cnt_reg <= 32'h0000_0000;
        nomaster <= 1'b0;
      end else if (nm_cnt_reg == 32'(NOMAST_CYC - 1)) begin
        nomaster <= 1'b1;
      end else begin
        nm_cnt_reg <= nm_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Software reset held exactly as written, not stretched
  always_ff @(posedge clock) begin
    if (internal_rst) begin
      sw_rst_reg <= 1'b0;
      io_control_on <= 1'b1;
    end else if (clk_en) begin
      if (ctl_wr4) begin
        sw_rst_reg <= 1'b1;
        io_control_on <= 1'b0;
      end else if (ctl_wr5) begin
        sw_rst_reg <= 1'b0;
        io_control_on <= 1'b1;
      end else if (ctl_wr6) begin
        sw_rst_reg <= 1'b1;
      end
    end
  end
  assign extension_io_reset_line = sw_rst_reg || nomaster;

  // ****************************************
  // Access watchdog and self reset
  // ****************************************
  logic [31:0] wd_cnt_reg, hold_cnt_reg;

  always_ff @(posedge clock) begin
    if (internal_rst) begin
      wd_cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (startup_flag || (acc && pready && !is_chk)) begin
        wd_cnt_reg <= 32'h0000_0000;
      end else if (wd_cnt_reg != 32'(WDOG_CYC - 1)) begin
        wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      unit_reset <= 1'b0;
      hold_cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (unit_reset) begin
        if (hold_cnt_reg == 32'(HOLD_CYC - 1)) begin
          unit_reset <= 1'b0;
          hold_cnt_reg <= 32'h0000_0000;
        end else begin
          hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
        end
      end else if (wd_cnt_reg == 32'(WDOG_CYC - 1)) begin
        unit_reset <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup && !pwrite) begin
      if (hit(ofs, `EBWC_ADDR_LOOP_IO) && !bcast) begin
        prdata <= {24'h000000, loop_io_reg};
      end else if (hit(ofs, `EBWC_ADDR_LOOP_REG) && !bcast) begin
        prdata <= {24'h000000, loop_reg_reg};
      end else if (is_chk_i) begin
        prdata <= {24'h000000, jmp_i_reg};
      end else if (is_chk_ii) begin
        prdata <= {24'h000000, jmp_ii_reg};
      end else if (hit(ofs, `EBWC_ADDR_LATCH) && !bcast) begin
        prdata <= {24'h000000, latch_reg};
      end else if (hit(ofs, `EBWC_ADDR_STATUS) && !bcast) begin
        prdata <= {24'h000000, mast_reg[3:0], startup_flag, nomaster,
          en_ii_reg, en_i_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// >>> ebwc_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module ebwc_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Context and outputs
  input wire logic [7:0] jumper_i_pin,
  input wire logic [7:0] jumper_ii_pin,
  input wire logic aux_24v_output,
  input wire logic io_control_on,
  input wire logic access_acknowledge_err,
  input wire logic status_capture,
  input wire logic unit_reset,
  input wire logic startup_flag,
  input wire logic [7:0] int_limit
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  logic done, chk_wr, chk_match, user_wr, bc0, aux_cause, on5, chk_done;
  logic [7:0] wd;
  assign wd = pwdata[7:0];
  assign done = psel && penable && pready && pwrite;
  assign chk_wr = psel && penable && pwrite && paddr[11:3] == 9'h004;
  assign chk_match = paddr[2] ? wd == jumper_ii_pin : wd == jumper_i_pin;
  assign chk_done = done && chk_wr;
  assign user_wr = done && paddr[10:0] == 11'h008;
  assign bc0 = done && paddr == 12'h800;
  assign aux_cause = user_wr && !wd[7] && wd[2:0] inside {3'h2, 3'h3, 3'h4};
  assign on5 = done && paddr == 12'h014 && wd[2:0] == 3'h5;
  chk_ready_a: assert property (chk_wr && !unit_reset |-> pready == chk_match)
    else $error("check write ready does not follow jumper match");
  chk_capture_a: assert property (chk_done |=> !status_capture)
    else $error("check write captured access status");
  bcast_err_a: assert property (access_acknowledge_err |-> $past(bc0))
    else $error("addressing error without broadcast write to zero");
  aux_rise_a: assert property ($rose(aux_24v_output) |-> $past(aux_cause))
    else $error("aux output rose without on, pulse or invert code");
  pulse_len_a: assert property (user_wr && wd == 8'h03 |=> aux_24v_output [*8])
    else $error("aux pulse too short");
  limit_src_a: assert property ($changed(int_limit) |-> $past(user_wr) || unit_reset || $past(unit_reset))
    else $error("interrupt limit changed without user write");
  limit_val_a: assert property (user_wr && wd inside {8'h80, 8'h85, 8'h86} |=> int_limit == ($past(wd) == 8'h85 ? 8'h20 : 8'hA0))
    else $error("interrupt limit code gave wrong limit");
  wdog_gate_a: assert property ($rose(unit_reset) |-> !$past(startup_flag))
    else $error("self reset while start-up flag set");
  hold_len_a: assert property ($rose(unit_reset) |-> unit_reset [*8])
    else $error("self reset released too early");
  ctrl_on_a: assert property ($rose(io_control_on) |-> $past(on5) || unit_reset || $past(unit_reset))
    else $error("control enabled without valid register five write");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  bcast_c: cover property (bc0);
  refuse_c: cover property (chk_wr && !pready);
  wdog_c: cover property ($rose(unit_reset));
endmodule
`default_nettype wire

// >>> ebwc_bus_side.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Redundant CPU bus side
// ****************************************
module ebwc_bus_side #(
  parameter logic [7:0] JUMPER_PAT = 8'hA5
) (
  // Commands from the bench
  input wire logic ii_cmd,
  input wire logic sync_cmd,
  input wire logic fault_cmd,
  // Context toward the device
  output logic cpu_ii_side,
  output logic sync_mode,
  output logic freq_fault,
  output logic [7:0] jumper_i_pin,
  output logic [7:0] jumper_ii_pin
);
  // Each CPU acts on its own enables
  assign cpu_ii_side = ii_cmd;
  assign sync_mode = sync_cmd;
  assign freq_fault = fault_cmd;
  // Correct jumpers carry inverted patterns
  assign jumper_i_pin = JUMPER_PAT;
  assign jumper_ii_pin = ~JUMPER_PAT;
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ii_cmd = 1'h0;
  logic sync_cmd = 1'h0;
  logic fault_cmd = 1'h0;
  logic [31:0] prdata, icount;
  logic pready, pslverr, cpu_ii_side, sync_mode, freq_fault;
  logic aux_24v_output, extension_io_reset_line, io_control_on;
  logic access_acknowledge_err, status_capture, temp_inhibit;
  logic unit_reset, startup_flag, ok, serr;
  logic [7:0] jumper_i_pin, jumper_ii_pin, int_limit, q;
  ebwc_pkg::ebwc_int_ctrl_type int_ctrl;
  int errors = 0;
  int cmp_count = 0;
  int n_err = 0;
  int n_clr = 0;
  int n_rst = 0;
  logic [7:0] pats [4] = '{8'h55, 8'hAA, 8'h00, 8'hFF};
  logic [7:0] ucode [8] = '{8'h02, 8'h01, 8'h04, 8'h04, 8'h00, 8'h78,
    8'h7A, 8'h01};
  logic uexp [8] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
  logic [7:0] icode [6] = '{8'h80, 8'h81, 8'h85, 8'h86, 8'h85, 8'h80};
  logic [8:0] iexp [6] = '{9'h1A0, 9'h0A0, 9'h020, 9'h0A0, 9'h020, 9'h1A0};
  logic mii [6] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic msync [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  logic [7:0] mcode [6] = '{8'h22, 8'h22, 8'h54, 8'h22, 8'h44, 8'h32};
  logic [1:0] mexp [6] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2};
  logic [11:0] raddr [5] = '{12'h010, 12'h014, 12'h014, 12'h018, 12'h014};
  logic [7:0] rdat [5] = '{8'h14, 8'h04, 8'hFD, 8'h06, 8'h05};
  logic [1:0] rexp [5] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h1};
  always #50 clock = ~clock;
  ebwc_top #(.NOMAST_CYC(20), .WDOG_CYC(50), .HOLD_CYC(10)) i_ebwc_top (
    .clock, .srst, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_ii_side, .sync_mode,
    .jumper_i_pin, .jumper_ii_pin, .freq_fault, .aux_24v_output,
    .extension_io_reset_line, .io_control_on, .access_acknowledge_err,
    .status_capture, .temp_inhibit, .unit_reset, .startup_flag, .int_ctrl,
    .int_limit, .interval_count(icount));
  ebwc_bus_side i_ebwc_bus_side (.ii_cmd, .sync_cmd, .fault_cmd,
    .cpu_ii_side, .sync_mode, .freq_fault, .jumper_i_pin, .jumper_ii_pin);
  // ****************************************
  // Pulse counters
  // ****************************************
  always @(posedge clock) begin
    if (access_acknowledge_err === 1'h1) n_err++;
    if (int_ctrl.clear_all === 1'h1) n_clr++;
    if (int_ctrl.restart_interval === 1'h1) n_rst++;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    $display("counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
      input logic want);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 40);
    ok = pready;
    serr = pslverr;
    q = prdata[7:0];
    psel <= 1'h0;
    penable <= 1'h0;
    if (want && ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: no ready from %h", $time, a);
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d, 1'h1);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'h0, a, 8'h00, 1'h1);
  endtask
  task automatic wait_for(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? unit_reset : extension_io_reset_line) !== v &&
        n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n == 300) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out();
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    longint t0;
    tick(2);
    srst <= 1'h0;
    tick(3);
    chk({aux_24v_output, extension_io_reset_line, io_control_on}, 3'h1);
    chk(int_limit, 8'hA0);
    rd(12'h028);
    chk({q[3], q[2], q[0]}, 3'h5);
    $display("test reset values done");
    wr(12'h020, 8'hA5);
    wr(12'h024, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, 12'h020, 8'hA5 ^ (8'h01 << i), 1'h0);
      chk(ok, 1'h0);
    end
    $display("test check registers done");
    foreach (pats[i]) begin
      for (int a = 0; a < 8; a += 4) begin
        wr(a[11:0], pats[i]);
        rd(a[11:0]);
        chk(q, pats[i]);
      end
    end
    apb(1'h0, 12'h030, 8'h00, 1'h1);
    chk(serr, 1'h1);
    $display("test loop-back done");
    chk(n_err, 0);
    wr(12'h800, 8'h11);
    wr(12'h804, 8'h66);
    wr(12'h808, 8'h00);
    tick(2);
    chk(n_err, 1);
    rd(12'h004);
    chk(q, 8'h66);
    $display("test broadcast done");
    foreach (ucode[i]) begin
      wr(12'h008, ucode[i]);
      tick(1);
      chk(aux_24v_output, uexp[i]);
    end
    wr(12'h008, 8'h78);
    rd(12'h02C);
    chk(q, 8'h78);
    wr(12'h008, 8'h03);
    n = 0;
    tick(1);
    while (aux_24v_output === 1'h1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk(n >= 750 && n <= 1300, 1'h1);
    $display("test aux output done");
    wr(12'h008, 8'h84);
    tick(2);
    chk({n_clr[3:0], n_rst[3:0]}, 8'h11);
    chk(icount, 32'h0);
    foreach (icode[i]) begin
      wr(12'h008, icode[i]);
      tick(1);
      chk({int_ctrl.soft_inhibit, int_limit}, iexp[i]);
    end
    tick(1);
    chk(n_rst, 4);
    fault_cmd <= 1'h1;
    tick(4);
    wr(12'h008, 8'h85);
    tick(2);
    chk({n_rst[3:0], int_limit}, 12'h420);
    fault_cmd <= 1'h0;
    $display("test interrupt codes done");
    foreach (mcode[i]) begin
      ii_cmd <= mii[i];
      sync_cmd <= msync[i];
      tick(3);
      wr(12'h00C, mcode[i]);
      rd(12'h028);
      chk(q[1:0], mexp[i]);
    end
    ii_cmd <= 1'h0;
    sync_cmd <= 1'h0;
    $display("test mastership done");
    foreach (raddr[i]) begin
      wr(raddr[i], rdat[i]);
      tick(1);
      chk({extension_io_reset_line, io_control_on}, rexp[i]);
      tick(20);
      chk(extension_io_reset_line, rexp[i][1]);
    end
    $display("test i/o reset control done");
    wr(12'h00C, 8'h06);
    tick(1);
    chk(temp_inhibit, 1'h1);
    wait_for(1'h0, 1'h1);
    apb(1'h1, 12'h024, 8'h5A, 1'h1);
    apb(1'h0, 12'h004, 8'h00, 1'h0);
    chk(ok, 1'h0);
    tick(60);
    chk({unit_reset, startup_flag}, 2'h1);
    srst <= 1'h1;
    tick(2);
    srst <= 1'h0;
    tick(3);
    chk({temp_inhibit, extension_io_reset_line, io_control_on}, 3'h1);
    $display("test no master done");
    wr(12'h00C, 8'h86);
    t0 = $time;
    tick(1);
    chk({temp_inhibit, startup_flag}, 2'h2);
    tick(30);
    wr(12'h020, 8'hA5);
    wait_for(1'h1, 1'h1);
    n = int'(($time - t0) / 100);
    chk(n >= 50 && n <= 57, 1'h1);
    t0 = $time;
    wait_for(1'h1, 1'h0);
    n = int'(($time - t0) / 100);
    chk(n >= 10 && n <= 15, 1'h1);
    chk({startup_flag, temp_inhibit}, 2'h2);
    rd(12'h028);
    chk(q[2], 1'h0);
    $display("test watchdog done");
    close_out();
  end
  initial begin
    #(100 * 60000);
    errors++;
    $display("unexpected at %0t: run timeout", $time);
    close_out();
  end
endmodule
bind ebwc_top ebwc_chk i_ebwc_chk (.clock, .srst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .jumper_i_pin, .jumper_ii_pin,
  .aux_24v_output, .io_control_on, .access_acknowledge_err, .status_capture,
  .unit_reset, .startup_flag, .int_limit);
`default_nettype wire
